// >>> eac_defs.vh
/*
 * constants for the nvm access controller: register offsets, field
 * positions, mode codes and programming cycle counts.
 * assumes inclusion by bare name from the design files.
 */
`ifndef EAC_DEFS_VH
`define EAC_DEFS_VH

// ==========================================================
// register offsets, data space and short i/o space
`define EAC_IO_OFFSET       8'h20
`define EAC_OFF_CONTROL     8'h3F
`define EAC_OFF_DATA        8'h40
`define EAC_OFF_ADDR_LOW    8'h41
`define EAC_OFF_ADDR_HIGH   8'h42
`define EAC_OFF_TEMP        8'h43

// ==========================================================
// control register fields and data register reset value
`define EAC_BIT_READ        0
`define EAC_BIT_STROBE      1
`define EAC_BIT_MASTER      2
`define EAC_BIT_RIE         3
`define EAC_BIT_MODE_LO     4
`define EAC_BIT_MODE_HI     5
`define EAC_DATA_RESET      8'h00

// ==========================================================
// programming modes
`define EAC_MODE_ATOMIC     2'h0
`define EAC_MODE_ERASE      2'h1
`define EAC_MODE_WRITE      2'h2

// ==========================================================
// timing: programming cycles counted on the calibrated rc oscillator tick, master enable and stall counts on clk
`define EAC_RC_CYCLES_FULL  16'h6700
`define EAC_RC_CYCLES_HALF  16'h3380
`define EAC_MASTER_CYCLES   3'h4
`define EAC_WR_STALL        3'h2
`define EAC_RD_STALL        3'h4

`endif

// >>> eac_prog_timer.v
/*
 * programming timer: counts rc oscillator ticks for one array cycle.
 * assumes rc_tick is already synchronised, one clk pulse per rising rc edge.
 */
`timescale 1ns/1ps
`include "eac_defs.vh"

module eac_prog_timer #(
  parameter [15:0] FULL_COUNT = `EAC_RC_CYCLES_FULL,
  parameter [15:0] HALF_COUNT = `EAC_RC_CYCLES_HALF
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       start,
  input  wire [1:0] mode,
  input  wire       rc_tick,
  output reg        busy_q,
  output reg        done_q
);

  reg [15:0] cnt_q;

  // ==========================================================
  // counter: reset does not abort a running cycle
  always @(posedge clk) begin
    done_q <= 1'b0;
    if (start && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q  <= (mode == `EAC_MODE_ATOMIC) ? FULL_COUNT : HALF_COUNT;
    end else if (busy_q && rc_tick) begin
      if (cnt_q <= 16'h0001) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end else if (rst && !busy_q) begin
      cnt_q <= 16'h0000;
    end
  end

  // power-up value, kept without async reset so a reset cannot kill a cycle
  initial begin
    busy_q = 1'b0;
    done_q = 1'b0;
    cnt_q  = 16'h0000;
  end

endmodule

// >>> eac_nvm_ctrl.v
/*
 * cpu side access logic for the 512 byte data nvm array: address pair
 * with shared temporary byte, data and control registers, timed write.
 * assumes an 8-bit cpu i/o bus with single cycle rd/wr strobes, the
 * array memory held here, and an rc oscillator input on its own clock.
 * each level of the rc oscillator must last at least two clk periods,
 * or the synchroniser below misses its rising edges.
 * the array contents are unknown at power-up; nothing clears them.
 * a reset in mid-cycle lets the timed cycle run on to its end.
 */
// How it works
// - low byte write goes to temp; high byte write copies temp into low half
// - low byte read copies high half to temp; high read returns temp
// - temporary byte is also a plain readable and writable location
// - address pair selects one of 512 bytes, high byte at offset plus one
// - address register undefined after reset; software loads it first
// - data register holds write data, and read result after a read
// - mode 00 erase plus write, 01 erase, 10 write, 11 reserved
// - mode writes ignored while busy; reset clears mode unless busy
// - ready interrupt requested while strobe clear, enabled, global enable set, no cpu flash write active
// - master write enable self clears four clocks after being set
// - strobe starts programming only while master enable is still set
// - strobe stays set during programming, hardware clears it at the end
// - accepted write strobe stalls cpu two cycles
// - read strobe fetches byte at once, stalls cpu four cycles
// - during programming reads are refused and address cannot change
// - no programming while a cpu flash write is active
// - one byte erase plus write counts 26368 rc oscillator cycles, erase or write alone 13184
// - each register decodes at its data offset and at offset minus 0x20
// - reset during programming lets the running cycle complete
`timescale 1ns/1ps
`include "eac_defs.vh"

module eac_nvm_ctrl (
  input  wire       CLK,
  input  wire       SYS_RST,
  input  wire [7:0] BUS_ADDR,
  input  wire       BUS_IO_SPACE,
  input  wire       BUS_WR,
  input  wire       BUS_RD,
  input  wire [7:0] BUS_WDATA,
  output reg  [7:0] BUS_RDATA,
  input  wire       GLOBAL_IRQ_ENABLE,
  input  wire       FLASH_SELFPROG_ENABLE,
  input  wire       RC_OSC,
  output reg        READY_IRQ,
  output reg        CPU_STALL,
  output reg        NVM_BUSY
);

  // ==========================================================
  // decode: i/o space addresses sit 0x20 below data space
  function [7:0] eac_map;
    input [7:0] a;
    input       io;
    begin
      eac_map = io ? (a + `EAC_IO_OFFSET) : a;
    end
  endfunction

  // true when the bus address, in either space, names the given offset
  function eac_hit;
    input [7:0] a;
    input       io;
    input [7:0] off;
    begin
      eac_hit = (eac_map(a, io) == off);
    end
  endfunction

  wire       sel_ctl  = eac_hit(BUS_ADDR, BUS_IO_SPACE, `EAC_OFF_CONTROL);
  wire       sel_dat  = eac_hit(BUS_ADDR, BUS_IO_SPACE, `EAC_OFF_DATA);
  wire       sel_adl  = eac_hit(BUS_ADDR, BUS_IO_SPACE, `EAC_OFF_ADDR_LOW);
  wire       sel_adh  = eac_hit(BUS_ADDR, BUS_IO_SPACE, `EAC_OFF_ADDR_HIGH);
  wire       sel_tmp  = eac_hit(BUS_ADDR, BUS_IO_SPACE, `EAC_OFF_TEMP);

  // ==========================================================
  // rc oscillator sync: three flops, edge once stages two and three agree
  reg rc_s1_q;
  reg rc_s2_q;
  reg rc_s3_q;
  reg rc_lvl_q;

  // no reset: a reset must not drop or repeat a tick of a running cycle
  always @(posedge CLK) begin
    rc_s1_q <= RC_OSC;
    rc_s2_q <= rc_s1_q;
    rc_s3_q <= rc_s2_q;
    if (rc_s2_q == rc_s3_q)
      rc_lvl_q <= rc_s3_q;
  end

  initial begin
    rc_s1_q  = 1'b0;
    rc_s2_q  = 1'b0;
    rc_s3_q  = 1'b0;
    rc_lvl_q = 1'b0;
  end

  wire rc_tick = (rc_s2_q == rc_s3_q) && rc_s3_q && !rc_lvl_q;

  // ==========================================================
  // registers
  reg  [7:0] mem [0:511];
  reg  [7:0] addr_lo_q;
  reg  [7:0] addr_hi_q;
  reg  [7:0] temp_q;
  reg  [7:0] data_q;
  reg  [1:0] mode_q;
  reg        rie_q;
  reg        master_q;
  reg  [2:0] master_cnt_q;
  reg  [2:0] stall_cnt_q;
  reg  [8:0] prog_addr_q;
  reg  [7:0] prog_data_q;
  reg  [1:0] prog_mode_q;
  wire       busy;
  wire       done;

  wire [8:0] cur_addr = {addr_hi_q[0], addr_lo_q};
  wire       wr_ctl   = BUS_WR && sel_ctl;
  // strobe accepted only with master set and flash idle
  wire       start    = wr_ctl && BUS_WDATA[`EAC_BIT_STROBE] && master_q && !busy
                        && !FLASH_SELFPROG_ENABLE;
  wire       rd_go    = wr_ctl && BUS_WDATA[`EAC_BIT_READ] && !busy && !start;

  eac_prog_timer u_timer (
    .clk     (CLK),
    .rst     (SYS_RST),
    .start   (start),
    .mode    (mode_q),
    .rc_tick (rc_tick),
    .busy_q  (busy),
    .done_q  (done)
  );

  // ==========================================================
  // address pair and temporary byte, no reset: value undefined
  always @(posedge CLK) begin
    if (BUS_WR && sel_adl && !busy)
      temp_q <= BUS_WDATA;
    else if (BUS_WR && sel_tmp)
      temp_q <= BUS_WDATA;
    else if (BUS_RD && sel_adl)
      temp_q <= addr_hi_q;
    // high byte write moves the whole pair at once
    if (BUS_WR && sel_adh && !busy) begin
      addr_hi_q <= BUS_WDATA;
      addr_lo_q <= temp_q;
    end
  end

  // ==========================================================
  // data register
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      data_q <= `EAC_DATA_RESET;
    end else if (BUS_WR && sel_dat) begin
      data_q <= BUS_WDATA;
    end else if (rd_go) begin
      data_q <= mem[cur_addr];
    end
  end

  // ==========================================================
  // ready interrupt enable
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
      rie_q <= 1'b0;
    else if (wr_ctl)
      rie_q <= BUS_WDATA[`EAC_BIT_RIE];
  end

  // ==========================================================
  // master write enable, self clears four cycles after being set
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      master_q     <= 1'b0;
      master_cnt_q <= 3'h0;
    end else if (wr_ctl && BUS_WDATA[`EAC_BIT_MASTER]) begin
      master_q     <= 1'b1;
      master_cnt_q <= `EAC_MASTER_CYCLES;
    end else if (start || (wr_ctl && !BUS_WDATA[`EAC_BIT_MASTER])) begin
      master_q     <= 1'b0;
      master_cnt_q <= 3'h0;
    end else if (master_q) begin
      if (master_cnt_q == 3'h1)
        master_q <= 1'b0;
      master_cnt_q <= master_cnt_q - 3'h1;
    end
  end

  // ==========================================================
  // cpu stall counter
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
      stall_cnt_q <= 3'h0;
    else if (start)
      stall_cnt_q <= `EAC_WR_STALL;
    else if (rd_go)
      stall_cnt_q <= `EAC_RD_STALL;
    else if (stall_cnt_q != 3'h0)
      stall_cnt_q <= stall_cnt_q - 3'h1;
  end

  // ==========================================================
  // mode field: kept through reset while the array is busy
  always @(posedge CLK) begin
    if (SYS_RST) begin
      if (!busy)
        mode_q <= `EAC_MODE_ATOMIC;
    end else if (wr_ctl && !busy && !start) begin
      mode_q <= {BUS_WDATA[`EAC_BIT_MODE_HI], BUS_WDATA[`EAC_BIT_MODE_LO]};
    end
  end

  initial mode_q = `EAC_MODE_ATOMIC;

  // ==========================================================
  // array programming, committed when the timed cycle ends
  always @(posedge CLK) begin
    if (start) begin
      prog_addr_q <= cur_addr;
      prog_data_q <= data_q;
      prog_mode_q <= mode_q;
    end
    // write-only can only clear bits, so the byte wants an erase first
    // a reserved mode runs the half-length timed cycle and leaves the byte alone
    if (done) begin
      case (prog_mode_q)
        `EAC_MODE_ATOMIC: mem[prog_addr_q] <= prog_data_q;
        `EAC_MODE_ERASE:  mem[prog_addr_q] <= 8'hFF;
        `EAC_MODE_WRITE:  mem[prog_addr_q] <= mem[prog_addr_q] & prog_data_q;
        default:          mem[prog_addr_q] <= mem[prog_addr_q];
      endcase
    end
  end

  // ==========================================================
  // read mux and outputs; strobe bit reads busy
  reg [7:0] rdata_d;

  always @* begin
    rdata_d = 8'h00;
    if (sel_ctl)
      rdata_d = {2'h0, mode_q, rie_q, master_q, busy, 1'b0};
    else if (sel_dat)
      rdata_d = data_q;
    else if (sel_adl)
      rdata_d = addr_lo_q;
    else if (sel_adh || sel_tmp)
      rdata_d = temp_q;
  end

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
      BUS_RDATA <= 8'h00;
    else
      BUS_RDATA <= BUS_RD ? rdata_d : 8'h00;
  end

  // ==========================================================
  // ready request, a level while idle and enabled
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
      READY_IRQ <= 1'b0;
    else
      READY_IRQ <= rie_q && GLOBAL_IRQ_ENABLE && !busy && !start
                   && !FLASH_SELFPROG_ENABLE;
  end

  // ==========================================================
  // cpu stall, held while the stall counter runs
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
      CPU_STALL <= 1'b0;
    else
      CPU_STALL <= start || rd_go || (stall_cnt_q > 3'h1);
  end

  // ==========================================================
  // busy flag: no reset, it must stay up while a cycle runs on
  always @(posedge CLK) begin
    NVM_BUSY <= busy || start;
  end

  initial NVM_BUSY = 1'b0;

endmodule

// >>> eac_rc_model.sv
/* rc oscillator model, free running programming timebase.
   assumes the controller synchronises it to its own clock. */
`timescale 1ns/1ps
// ==========================================================
// oscillator
module eac_rc_model #(
  parameter realtime HALF_NS = 10.0
) (
  output logic rc_osc
);
  initial begin
    rc_osc = 1'b0;
    // offset keeps rc edges off the clk edges; each level spans two clk periods
    #1;
    forever #(HALF_NS) rc_osc = ~rc_osc;
  end
endmodule

// >>> eac_nvm_ctrl_chk.sv
/* port checker for the nvm access controller.
   assumes binding onto eac_nvm_ctrl, one clock domain. */
`timescale 1ns/1ps
// ==========================================================
// checker
module eac_nvm_ctrl_chk (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic [7:0] BUS_ADDR,
  input wire logic       BUS_IO_SPACE,
  input wire logic       BUS_WR,
  input wire logic       BUS_RD,
  input wire logic [7:0] BUS_WDATA,
  input wire logic [7:0] BUS_RDATA,
  input wire logic       FLASH_SELFPROG_ENABLE,
  input wire logic       GLOBAL_IRQ_ENABLE,
  input wire logic       READY_IRQ,
  input wire logic       CPU_STALL,
  input wire logic       NVM_BUSY
);
  wire [7:0] off     = BUS_IO_SPACE ? BUS_ADDR + 8'h20 : BUS_ADDR;
  wire       ctl_hit = off == 8'h3F;
  wire       map_hit = off >= 8'h3F && off <= 8'h43;
  wire       rd_go   = BUS_WR && ctl_hit && BUS_WDATA[0] && !BUS_WDATA[1] && !NVM_BUSY;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_stall2;
    CPU_STALL [*2] ##1 !CPU_STALL;
  endsequence
  sequence s_stall4;
    CPU_STALL [*4] ##1 !CPU_STALL;
  endsequence
  a_write_stall: assert property ($rose(NVM_BUSY) |-> s_stall2)
    else $error("write stall length");
  a_read_stall: assert property (rd_go |=> s_stall4)
    else $error("read stall length");
  a_stall_cause: assert property ($rose(CPU_STALL) |-> $past(BUS_WR) && $past(ctl_hit))
    else $error("stall without control write");
  a_busy_hold: assert property ($rose(NVM_BUSY) |-> NVM_BUSY [*8])
    else $error("busy dropped early");
  a_busy_quiet: assert property (NVM_BUSY && !CPU_STALL && BUS_WR && ctl_hit |=> !CPU_STALL)
    else $error("access taken while busy");
  a_flash_block: assert property (FLASH_SELFPROG_ENABLE && !NVM_BUSY |=> !NVM_BUSY)
    else $error("programming during flash write");
  a_irq_busy: assert property (NVM_BUSY && $past(NVM_BUSY) |-> !READY_IRQ)
    else $error("ready request while busy");
  a_irq_global: assert property (!GLOBAL_IRQ_ENABLE || FLASH_SELFPROG_ENABLE |=> !READY_IRQ)
    else $error("ready request while masked");
  a_unmapped_zero: assert property (BUS_RD && !map_hit |=> BUS_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind eac_nvm_ctrl eac_nvm_ctrl_chk u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .BUS_ADDR(BUS_ADDR),
  .BUS_IO_SPACE(BUS_IO_SPACE), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_WDATA(BUS_WDATA),
  .BUS_RDATA(BUS_RDATA), .FLASH_SELFPROG_ENABLE(FLASH_SELFPROG_ENABLE),
  .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .READY_IRQ(READY_IRQ), .CPU_STALL(CPU_STALL),
  .NVM_BUSY(NVM_BUSY));

// >>> test_eac_nvm_ctrl.sv
/* testbench for the nvm access controller: registers, address pair, timed write.
   assumes the rc model at 20 ns period, four clocks a tick, as programming timebase. */
`timescale 1ns/1ps
module test_eac_nvm_ctrl;
  logic       clk;
  logic       sys_rst;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic       bus_io;
  logic       bus_wr;
  logic       bus_rd;
  logic       gie;
  logic       flash_en;
  wire        rc_osc;
  wire  [7:0] bus_rdata;
  wire        ready_irq;
  wire        cpu_stall;
  wire        nvm_busy;
  int         failures;
  int         tests_run;
  int         cyc;
  realtime    t0;
  // {io, address, write data, expected read}
  localparam logic [27:0] ROWS [8] = '{28'h0_40_5A_5A, 28'h1_20_C3_C3, 28'h0_43_3C_3C,
    28'h1_23_96_96, 28'h0_3F_38_38, 28'h1_1F_20_20, 28'h0_50_77_00, 28'h0_3F_10_10};
  eac_rc_model u_rc (.rc_osc(rc_osc));
  eac_nvm_ctrl dut (.CLK(clk), .SYS_RST(sys_rst), .BUS_ADDR(bus_addr), .BUS_IO_SPACE(bus_io),
    .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata),
    .GLOBAL_IRQ_ENABLE(gie), .FLASH_SELFPROG_ENABLE(flash_en), .RC_OSC(rc_osc),
    .READY_IRQ(ready_irq), .CPU_STALL(cpu_stall), .NVM_BUSY(nvm_busy));
  // ==========================================================
  // bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {bus_io, bus_addr, bus_wdata, bus_wr} <= {io, a, d, 1'b1};
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rdc(input logic io, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    {bus_io, bus_addr, bus_rd} <= {io, a, 1'b1};
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, e);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // stimulus
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    failures = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    {bus_addr, bus_wdata} = 16'h0000;
    {bus_io, bus_wr, bus_rd, gie, flash_en} = 5'h00;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(1'b0, 8'h40, 8'h00);
    rdc(1'b0, 8'h3F, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      wr(ROWS[i][24], ROWS[i][23:16], ROWS[i][15:8]);
      rdc(ROWS[i][24], ROWS[i][23:16], ROWS[i][7:0]);
    end
    $display("register rows done");
    wr(1'b0, 8'h41, 8'hAB);
    rdc(1'b0, 8'h43, 8'hAB);
    wr(1'b0, 8'h42, 8'h01);
    rdc(1'b0, 8'h41, 8'hAB);
    rdc(1'b1, 8'h23, 8'h01);
    rdc(1'b0, 8'h42, 8'h01);
    $display("address pair done");
    wr(1'b0, 8'h3F, 8'h14);
    rdc(1'b0, 8'h3F, 8'h14);
    repeat (4) @(posedge clk);
    rdc(1'b0, 8'h3F, 8'h10);
    wr(1'b0, 8'h3F, 8'h12);
    #1 chk(nvm_busy, 1'b0);
    @(posedge clk);
    flash_en <= 1'b1;
    wr(1'b0, 8'h3F, 8'h14);
    wr(1'b0, 8'h3F, 8'h16);
    #1 chk(nvm_busy, 1'b0);
    @(posedge clk);
    flash_en <= 1'b0;
    repeat (6) @(posedge clk);
    $display("refused starts done");
    wr(1'b0, 8'h40, 8'h00);
    wr(1'b0, 8'h3F, 8'h14);
    wr(1'b1, 8'h1F, 8'h16);
    #1 chk(nvm_busy, 1'b1);
    t0 = $realtime;
    wr(1'b0, 8'h42, 8'h00);
    wr(1'b0, 8'h3F, 8'h21);
    rdc(1'b0, 8'h3F, 8'h12);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk(nvm_busy, 1'b1);
    rdc(1'b0, 8'h3F, 8'h12);
    for (int n = 0; n < 60000 && nvm_busy; n++) begin
      @(posedge clk);
      #1;
    end
    if (nvm_busy) begin
      failures++;
      report_and_stop();
    end
    cyc = int'(($realtime - t0) / 5.0);
    chk(cyc > 52725 && cyc < 52745, 1'b1);
    rdc(1'b0, 8'h3F, 8'h10);
    rdc(1'b0, 8'h41, 8'hAB);
    rdc(1'b1, 8'h22, 8'h01);
    wr(1'b0, 8'h3F, 8'h11);
    #1 chk(cpu_stall, 1'b1);
    rdc(1'b0, 8'h40, 8'hFF);
    $display("timed write done");
    @(posedge clk);
    gie <= 1'b1;
    wr(1'b0, 8'h3F, 8'h08);
    repeat (2) @(posedge clk);
    #1 chk(ready_irq, 1'b1);
    @(posedge clk);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(ready_irq, 1'b0);
    $display("ready request done");
    report_and_stop();
  end
endmodule
